// ===== design/bmsfp_top.sv
// bus-matching fifo: port A writes 36-bit words, port B reads them sized
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps

// Contract
// - port A has 36-bit two-way data bus
// - port B has 36-bit two-way data bus; here its input side is unused
// - near empty low when count at/below lower
// - near full low when free at/below upper
// - endian high at reset: big-endian
// - endian low at reset: little-endian
// - after reset pin picks standard or fwft
// - bus match picks byte/word or long
// - port A transfers on its clock rise
// - port A flags change on port A rise
// - port B transfers on its clock rise
// - port B flags change on port B rise
// - port A transfers need chip select low
// - port A drivers off when deselected
// - port B transfers need chip select low
// - port B drivers off when deselected
// - standard mode: flag shows buffer empty
// - fwft mode: flag shows output data valid
// - port A transfers need gate high
// - port B transfers need gate high
// - input flag: full or write space
// - mail select puts mailbox on port B
module bmsfp_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire bmsfp_pkg::bmsfp_regreq_s reg_req,
    output logic [31:0] reg_rdata,
    input wire logic port_a_clk,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_gate,
    input wire logic port_a_write_sel,
    input wire logic port_a_mail_select,
    input wire logic [35:0] port_a_bus_in,
    output logic [35:0] port_a_bus_out,
    output logic port_a_bus_oe,
    input wire logic port_b_clk,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_gate,
    input wire logic port_b_read_sel,
    input wire logic port_b_mail_select,
    input wire logic [35:0] port_b_bus_in,
    output logic [35:0] port_b_bus_out,
    output logic port_b_bus_oe,
    input wire logic endian_timing_select,
    input wire logic bus_match_select,
    input wire logic port_b_size,
    output logic full_input_ready_flag,
    output logic near_full_flag,
    output logic empty_output_ready_flag,
    output logic near_empty_flag
);
    // ************************************************
    // storage and state
    // ************************************************
    logic [35:0] mem [0:4095];
    bmsfp_pkg::bmsfp_state_s state_reg;
    bmsfp_pkg::bmsfp_state_s state_next;
    logic mem_we;

    // ************************************************
    // operating notes
    // ************************************************
    // port clocks:
    // - both port clocks are sampled as data on clk
    // - a transfer is a sampled low-to-high step
    // - port clocks must run at half clk or slower
    // - a faster port clock loses rises silently
    // port A:
    // - write select high stores the bus word
    // - write select low reads back the count
    // - mail select steers a write to the mailbox
    // - a mailbox write leaves the count alone
    // - writes into a full buffer are dropped
    // - no error flag exists for a dropped write
    // port B:
    // - read select and gate high pop or step
    // - mail select high shows the mailbox word
    // - a mailbox read never pops the fifo
    // - portions leave low aligned on the bus
    // - bytes use bits 8:0, words bits 17:0
    // - long mode sends a word in one step
    // endian and width:
    // - endian strap caught on every reset edge
    // - the last reset edge sets byte order
    // - width and endian pins must stay still
    // - moving them mid-word mixes two layouts
    // width table:
    // - bus match low: one long portion
    // - match high, size low: two words
    // - match high, size high: four bytes
    // order table:
    // - big endian: portion index counts down
    // - little endian: index counts up
    // - the step count starts at zero per word
    // timing modes:
    // - standard mode needs a read per word
    // - fall-through prefetches the head word
    // - the head word sits in the holding reg
    // - the held word no longer counts as stored
    // - so near empty falls one word early
    // - the mode bit lags the pin by one clk
    // flags:
    // - port A flags move on a port A rise only
    // - port B flags move on a port B rise only
    // - flags use the count after the transfer
    // - thresholds compare at-or-below, low active
    // - threshold writes show at the next rise
    // - input flag high while space is left, low from reset to the first port A rise
    // reset:
    // - synchronous and active high
    // - pointers, count and held word clear
    // - thresholds return to reset values
    // - near full leaves reset high
    // - memory words are kept, pointers clear
    // register port:
    // - writes land on the next clk edge
    // - read data stands one cycle, else zero
    // - unmapped writes ignored, reads give 0
    // - write and read never share a cycle
    // - thresholds sit in write data 12:0
    // status word:
    // - bits 12:0 stored count
    // - bit 16 fall-through mode
    // - bit 17 big endian
    // - other bits read as zero
    // hazards:
    // - a glitch shorter than clk is missed
    // - a one-clk glitch is a real rise
    // - both ports may move on one clk edge
    // - push and pop together keep the count
    // - memory is read combinationally
    // - prefetch waits for a stored word
    // trade-offs:
    // - one clock avoids flag crossings
    // - the price is the half-rate limit
    // - sampling adds one clk of latency
    // - registered flags never glitch
    // - drive enables lag chip select by one clk
    // limitations:
    // - no retransmit, no partial reset
    // - no port B writes; its input is unused
    // - no mailbox flags; new mail overwrites
    // - port A read data is the count only

    // pick one portion of a word for port B, low aligned
    function automatic logic [35:0] slice_out(
        input logic [35:0] word,
        input logic [1:0] part,
        input logic [1:0] last,
        input logic big,
        input logic matched,
        input logic byte_mode
    );
        logic [1:0] k;
        logic [35:0] shifted;
        k = big ? last - part : part;
        if (!matched) begin
            slice_out = word;
        end else if (byte_mode) begin
            shifted = word >> (k * bmsfp_pkg::BYTE_W);
            slice_out = {27'h0000000, shifted[8:0]};
        end else begin
            shifted = word >> (k * bmsfp_pkg::HALF_W);
            slice_out = {18'h00000, shifted[17:0]};
        end
    endfunction

    // ************************************************
    // next-state logic
    // ************************************************
    // port clocks are plain inputs sampled on clk; a transfer is a detected rise
    always_comb begin
        logic a_rise;
        logic b_rise;
        logic a_wr;
        logic a_rd;
        logic b_rd;
        logic push;
        logic pop;
        logic [1:0] last;
        logic [12:0] free;
        logic b_more;
        a_rise = 1'b0;
        b_rise = 1'b0;
        a_wr = 1'b0;
        a_rd = 1'b0;
        b_rd = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        last = 2'h0;
        free = 13'h0000;
        b_more = 1'b0;
        state_next = state_reg;
        mem_we = 1'b0;

        state_next.a_clk_prev = port_a_clk;
        state_next.b_clk_prev = port_b_clk;
        a_rise = port_a_clk && !state_reg.a_clk_prev;
        b_rise = port_b_clk && !state_reg.b_clk_prev;
        // a transfer needs select low and gate high on the rise
        a_wr = a_rise && !port_a_chip_select_n && port_a_gate && port_a_write_sel;
        a_rd = a_rise && !port_a_chip_select_n && port_a_gate && !port_a_write_sel;
        b_rd = b_rise && !port_b_chip_select_n && port_b_gate && port_b_read_sel
            && !port_b_mail_select;

        // mailbox bypass from port A
        if (a_wr && port_a_mail_select) begin
            state_next.mail1 = port_a_bus_in;
        end

        // portions per word: 1 long, 2 word, 4 byte
        if (!bus_match_select) begin
            last = 2'h0;
        end else if (port_b_size) begin
            last = 2'h3;
        end else begin
            last = 2'h1;
        end

        // writes into a full buffer are dropped
        push = a_wr && !port_a_mail_select && (state_reg.count != bmsfp_pkg::DEPTH);
        mem_we = push;
        if (push) begin
            state_next.wr_ptr = state_reg.wr_ptr + 12'h001;
        end

        // read side: holding word is sliced into portions
        if (state_reg.fwft) begin
            if (b_rd && state_reg.cur_valid) begin
                if (state_reg.part == last) begin
                    state_next.cur_valid = 1'b0;
                    state_next.part = 2'h0;
                end else begin
                    state_next.part = state_reg.part + 2'h1;
                end
            end
            // head word falls through without a read request
            if (!state_next.cur_valid && state_reg.count != 13'h0000) begin
                state_next.cur = mem[state_reg.rd_ptr];
                state_next.cur_valid = 1'b1;
                state_next.part = 2'h0;
                pop = 1'b1;
            end
        end else if (b_rd) begin
            if (state_reg.cur_valid && state_reg.part != last) begin
                state_next.part = state_reg.part + 2'h1;
            end else if (state_reg.count != 13'h0000) begin
                state_next.cur = mem[state_reg.rd_ptr];
                state_next.cur_valid = 1'b1;
                state_next.part = 2'h0;
                pop = 1'b1;
            end else begin
                // reading an empty buffer leaves everything alone
                state_next.cur_valid = state_reg.cur_valid;
            end
        end
        if (pop) begin
            state_next.rd_ptr = state_reg.rd_ptr + 12'h001;
        end
        state_next.count = state_reg.count + {12'h000, push} - {12'h000, pop};
        free = bmsfp_pkg::DEPTH - state_next.count;

        // port A flags move only on a port A rise
        if (a_rise) begin
            state_next.full_ir = (state_next.count != bmsfp_pkg::DEPTH);
            state_next.near_full = (free > state_reg.upper);
        end

        // port B flags move only on a port B rise
        b_more = state_next.cur_valid && (state_next.part != last);
        if (b_rise) begin
            if (state_reg.fwft) begin
                state_next.empty_or = state_next.cur_valid;
            end else begin
                state_next.empty_or = (state_next.count != 13'h0000) || b_more;
            end
            state_next.near_empty = (state_next.count > state_reg.lower);
        end

        // port B drivers: mailbox or sliced fifo word
        state_next.b_oe = !port_b_chip_select_n && port_b_read_sel;
        if (port_b_mail_select) begin
            state_next.b_out = state_reg.mail1;
        end else begin
            state_next.b_out = slice_out(state_next.cur, state_next.part, last,
                state_reg.big_endian, bus_match_select, port_b_size);
        end

        // port A reads return the word count; no other read source exists here
        state_next.a_oe = !port_a_chip_select_n && !port_a_write_sel;
        if (a_rd) begin
            state_next.a_out = {23'h000000, state_reg.count};
        end

        // timing mode follows the pin once reset is gone; writer keeps it static
        state_next.fwft = !endian_timing_select;

        // register port
        state_next.rdata = 32'h00000000;
        if (reg_req.wr) begin
            case (reg_req.addr)
                bmsfp_pkg::LOWER_THRESH_OFS: begin
                    state_next.lower = reg_req.wdata[12:0];
                end
                bmsfp_pkg::UPPER_THRESH_OFS: begin
                    state_next.upper = reg_req.wdata[12:0];
                end
                default: begin
                    state_next.lower = state_next.lower;
                end
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                bmsfp_pkg::LOWER_THRESH_OFS: begin
                    state_next.rdata = {19'h00000, state_reg.lower};
                end
                bmsfp_pkg::UPPER_THRESH_OFS: begin
                    state_next.rdata = {19'h00000, state_reg.upper};
                end
                bmsfp_pkg::STATUS_OFS: begin
                    state_next.rdata[bmsfp_pkg::ST_COUNT_LSB +: 13] = state_reg.count;
                    state_next.rdata[bmsfp_pkg::ST_FWFT_BIT] = state_reg.fwft;
                    state_next.rdata[bmsfp_pkg::ST_BIG_BIT] = state_reg.big_endian;
                end
                default: begin
                    state_next.rdata = 32'h00000000;
                end
            endcase
        end

        // master reset: clear pointers, catch endian strap
        if (sys_rst) begin
            state_next = '0;
            state_next.a_clk_prev = port_a_clk;
            state_next.b_clk_prev = port_b_clk;
            state_next.big_endian = endian_timing_select;
            state_next.fwft = 1'b0;
            state_next.lower = bmsfp_pkg::LOWER_THRESH_RST;
            state_next.upper = bmsfp_pkg::UPPER_THRESH_RST;
            state_next.near_full = 1'b1;
            mem_we = 1'b0;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    // reset is synchronous, so catching the strap value here is safe
    always_ff @(posedge clk) begin
        state_reg <= state_next;
    end

    // memory array kept outside the state struct; contents need no reset
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[state_reg.wr_ptr] <= port_a_bus_in;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign reg_rdata = state_reg.rdata;
    assign port_a_bus_out = state_reg.a_out;
    assign port_a_bus_oe = state_reg.a_oe;
    assign port_b_bus_out = state_reg.b_out;
    assign port_b_bus_oe = state_reg.b_oe;
    assign full_input_ready_flag = state_reg.full_ir;
    assign near_full_flag = state_reg.near_full;
    assign empty_output_ready_flag = state_reg.empty_or;
    assign near_empty_flag = state_reg.near_empty;

endmodule

// ===== include/bmsfp_pkg.sv
// package: constants and carrier types for the bus-matching fifo port block
package bmsfp_pkg;
    // ************************************************
    // geometry
    // ************************************************
    localparam int DATA_W = 36;
    localparam int PTR_W = 12;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] DEPTH = 13'h1000;
    localparam int BYTE_W = 9;
    localparam int HALF_W = 18;
    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] LOWER_THRESH_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] UPPER_THRESH_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
    // status fields
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_FWFT_BIT = 16;
    localparam int ST_BIG_BIT = 17;
    // reset values
    localparam logic [CNT_W-1:0] LOWER_THRESH_RST = 13'h0008;
    localparam logic [CNT_W-1:0] UPPER_THRESH_RST = 13'h0008;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bmsfp_regreq_s;

    // state of the block, apart from the memory array
    typedef struct packed {
        logic a_clk_prev;
        logic b_clk_prev;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic [DATA_W-1:0] cur;
        logic cur_valid;
        logic [1:0] part;
        logic big_endian;
        logic fwft;
        logic [DATA_W-1:0] mail1;
        logic [CNT_W-1:0] lower;
        logic [CNT_W-1:0] upper;
        logic [31:0] rdata;
        logic [DATA_W-1:0] a_out;
        logic a_oe;
        logic [DATA_W-1:0] b_out;
        logic b_oe;
        logic full_ir;
        logic empty_or;
        logic near_full;
        logic near_empty;
    } bmsfp_state_s;
endpackage

// ===== tb/bmsfp_assertions.sv
// checker: port-level properties of the bus-matching fifo block
`timescale 1ns/100ps
module bmsfp_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire bmsfp_pkg::bmsfp_regreq_s reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic port_a_clk,
    input wire logic port_a_chip_select_n,
    input wire logic port_a_gate,
    input wire logic port_a_write_sel,
    input wire logic [35:0] port_a_bus_out,
    input wire logic port_a_bus_oe,
    input wire logic port_b_clk,
    input wire logic port_b_chip_select_n,
    input wire logic port_b_bus_oe,
    input wire logic endian_timing_select,
    input wire logic full_input_ready_flag,
    input wire logic near_full_flag,
    input wire logic empty_output_ready_flag,
    input wire logic near_empty_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic big_reg;
    // strap copy: endian is latched only while reset is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            big_reg <= endian_timing_select;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    property p_a_oe;
        port_a_bus_oe |-> $past(!port_a_chip_select_n && !port_a_write_sel);
    endproperty
    a_a_oe: assert property (p_a_oe)
        else $error("port a driven while deselected");
    property p_b_oe;
        $past(port_b_chip_select_n) |-> !port_b_bus_oe;
    endproperty
    a_b_oe: assert property (p_b_oe)
        else $error("port b driven while deselected");
    // flags may only move one cycle after a seen port clock rise
    property p_a_flags;
        !$past(sys_rst) && ($changed(full_input_ready_flag) || $changed(near_full_flag))
            |-> $past(port_a_clk) && !$past(port_a_clk, 2);
    endproperty
    a_a_flags: assert property (p_a_flags)
        else $error("port a flag moved without a port a rise");
    property p_b_flags;
        !$past(sys_rst) && ($changed(empty_output_ready_flag) || $changed(near_empty_flag))
            |-> $past(port_b_clk) && !$past(port_b_clk, 2);
    endproperty
    a_b_flags: assert property (p_b_flags)
        else $error("port b flag moved without a port b rise");
    property p_a_read;
        !$past(sys_rst) && $changed(port_a_bus_out) |-> $past(port_a_clk) && !$past(port_a_clk, 2)
            && $past(!port_a_chip_select_n && port_a_gate && !port_a_write_sel);
    endproperty
    a_a_read: assert property (p_a_read)
        else $error("port a output changed without a gated read");
    property p_rdata_idle;
        !$past(reg_req.rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_big;
        $past(reg_req.rd && reg_req.addr == bmsfp_pkg::STATUS_OFS) |-> reg_rdata[17] == big_reg;
    endproperty
    a_big: assert property (p_big)
        else $error("endian bit differs from reset strap");
    property p_fwft;
        $past(reg_req.rd && reg_req.addr == bmsfp_pkg::STATUS_OFS)
            |-> reg_rdata[16] == !$past(endian_timing_select, 2);
    endproperty
    a_fwft: assert property (p_fwft)
        else $error("timing mode bit differs from pin");
    c_full: cover property (!full_input_ready_flag);
    c_a_read: cover property ($changed(port_a_bus_out));
    c_stat: cover property ($past(reg_req.rd) && reg_rdata[17]);
endmodule

// ===== tb/bmsfp_far_end.sv
// far-end model: port A writing processor and port B reading processor
`timescale 1ns/100ps
module bmsfp_far_end (
    input wire logic clk,
    output logic port_a_clk,
    output logic port_a_chip_select_n,
    output logic port_a_gate,
    output logic port_a_write_sel,
    output logic [35:0] port_a_bus_in,
    output logic port_b_clk,
    output logic port_b_chip_select_n,
    output logic port_b_gate,
    output logic port_b_read_sel
);
    // idle: clocks low, port A released, port B kept selected for output
    initial begin
        port_a_clk = 1'h0;
        port_a_chip_select_n = 1'h1;
        port_a_gate = 1'h0;
        port_a_write_sel = 1'h0;
        port_a_bus_in = 36'h0;
        port_b_clk = 1'h0;
        port_b_chip_select_n = 1'h0;
        port_b_gate = 1'h0;
        port_b_read_sel = 1'h1;
    end
    // one port A rise; controls set a cycle early and held past the rise
    task automatic a_op(input logic cs_n, input logic g, input logic wr, input logic [35:0] d);
        @(posedge clk);
        port_a_chip_select_n <= cs_n;
        port_a_gate <= g;
        port_a_write_sel <= wr;
        port_a_bus_in <= d;
        @(posedge clk);
        port_a_clk <= 1'h1;
        @(posedge clk);
        port_a_clk <= 1'h0;
        port_a_chip_select_n <= 1'h1;
        port_a_gate <= 1'h0;
        port_a_bus_in <= ~d; // released bus must not look like the old word
        @(posedge clk);
        @(negedge clk);
    endtask
    // one port B rise; the pin levels for width and timing never move here
    task automatic b_op(input logic cs_n, input logic g);
        @(posedge clk);
        port_b_chip_select_n <= cs_n;
        port_b_gate <= g;
        @(posedge clk);
        port_b_clk <= 1'h1;
        @(posedge clk);
        port_b_clk <= 1'h0;
        port_b_chip_select_n <= 1'h0;
        port_b_gate <= 1'h0;
        @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// ===== tb/bmsfp_top_tb.sv
// testbench: bus-matching fifo ports, table cases then edge cases
`timescale 1ns/100ps
module bmsfp_top_tb;
    typedef struct packed {
        logic big;
        logic bm;
        logic sz;
        logic [2:0] n;
    } bmsfp_row_s;
    localparam logic [35:0] WORD = 36'h9A5C30F17;
    // rows: {strap, bus match, size, portions per word}
    bmsfp_row_s rows [6] = '{6'h21, 6'h3C, 6'h32, 6'h1C, 6'h12, 6'h01};
    logic clk, sys_rst, port_a_clk, port_a_chip_select_n, port_a_gate, port_a_write_sel;
    logic port_a_bus_oe, port_b_clk, port_b_chip_select_n, port_b_gate, port_b_read_sel;
    logic port_b_bus_oe, endian_timing_select, bus_match_select, port_b_size;
    logic port_a_mail_select, port_b_mail_select;
    logic full_input_ready_flag, near_full_flag, empty_output_ready_flag, near_empty_flag;
    logic [35:0] port_a_bus_in, port_a_bus_out, port_b_bus_out;
    logic [31:0] reg_rdata;
    bmsfp_pkg::bmsfp_regreq_s reg_req;
    int err_total, checks;
    bmsfp_top u_dut (.*, .port_b_bus_in(36'h0));
    bmsfp_far_end u_far (.*);
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // strap pins only move while reset is held, so they stay static in use
    task automatic do_reset(input logic big, input logic bm, input logic sz);
        @(posedge clk);
        sys_rst <= 1'h1;
        endian_timing_select <= big;
        bus_match_select <= bm;
        port_b_size <= sz;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        reg_req.wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        reg_req.rd <= 1'h0;
        @(negedge clk);
        check({4'h0, reg_rdata}, {4'h0, exp});
    endtask
    // a port A read hands back the stored word count
    task automatic a_count(input logic [12:0] exp);
        u_far.a_op(1'h0, 1'h1, 1'h0, 36'h0);
        check(port_a_bus_out, {23'h0, exp});
    endtask
    function automatic logic [35:0] portion(input logic [35:0] w, input int n, input int i,
        input logic big);
        int k;
        k = big ? n - 1 - i : i;
        return (w >> (k * (36 / n))) & ((36'h1 << (36 / n)) - 36'h1);
    endfunction
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        sys_rst = 1'h1;
        reg_req = '0;
        endian_timing_select = 1'h1;
        bus_match_select = 1'h0;
        port_b_size = 1'h0;
        port_a_mail_select = 1'h0;
        port_b_mail_select = 1'h0;
        err_total = 0;
        checks = 0;
        foreach (rows[r]) begin
            do_reset(rows[r].big, rows[r].bm, rows[r].sz);
            u_far.a_op(1'h0, 1'h1, 1'h1, WORD);
            repeat (2) u_far.b_op(1'h0, 1'h0);
            check(empty_output_ready_flag, 1'h1);
            for (int i = 0; i < rows[r].n; i++) begin
                if (rows[r].big) u_far.b_op(1'h0, 1'h1);
                check(port_b_bus_out, portion(WORD, rows[r].n, i, rows[r].big));
                if (!rows[r].big) u_far.b_op(1'h0, 1'h1);
            end
            u_far.b_op(1'h0, 1'h0);
            check(empty_output_ready_flag, 1'h0);
            check(near_empty_flag, 1'h0);
            reg_rd(bmsfp_pkg::STATUS_OFS, {14'h0, rows[r].big, !rows[r].big, 16'h0});
        end
        // gating, thresholds at their boundaries, then full and empty refusals
        do_reset(1'h1, 1'h0, 1'h0);
        u_far.a_op(1'h1, 1'h1, 1'h1, WORD);
        u_far.a_op(1'h0, 1'h0, 1'h1, WORD);
        a_count(13'h0);
        reg_rd(4'hC, 32'h0);
        reg_wr(bmsfp_pkg::LOWER_THRESH_OFS, 32'h2);
        repeat (3) u_far.a_op(1'h0, 1'h1, 1'h1, WORD);
        u_far.b_op(1'h1, 1'h1);
        u_far.b_op(1'h0, 1'h0);
        check(near_empty_flag, 1'h1);
        a_count(13'h3);
        reg_wr(bmsfp_pkg::LOWER_THRESH_OFS, 32'h3);
        u_far.b_op(1'h0, 1'h0);
        check(near_empty_flag, 1'h0);
        check(near_full_flag, 1'h1);
        reg_wr(bmsfp_pkg::UPPER_THRESH_OFS, 32'hFFD);
        a_count(13'h3);
        check(near_full_flag, 1'h0);
        repeat (4093) u_far.a_op(1'h0, 1'h1, 1'h1, WORD);
        check(full_input_ready_flag, 1'h0);
        u_far.a_op(1'h0, 1'h1, 1'h1, ~WORD);
        a_count(13'h1000);
        repeat (4097) u_far.b_op(1'h0, 1'h1);
        check(port_b_bus_out, WORD);
        check(empty_output_ready_flag, 1'h0);
        a_count(13'h0);
        // mailbox bypass: word shows on port B, fifo count untouched
        @(posedge clk);
        port_a_mail_select <= 1'h1;
        u_far.a_op(1'h0, 1'h1, 1'h1, 36'h123456789);
        @(posedge clk);
        port_a_mail_select <= 1'h0;
        port_b_mail_select <= 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(port_b_bus_out, 36'h123456789);
        a_count(13'h0);
        report_and_stop();
    end
    // watchdog: the whole sequence needs about 33000 cycles
    initial begin
        repeat (95000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule
bind bmsfp_top bmsfp_assertions u_chk (.*);
